// >>> atf_engine_model.sv
// Behavioural media engine that finishes each accepted command.
`timescale 1ns/10ps
module atf_engine_model
    import atf_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       cmd_start,
    input  atf_cmd_t        cmd,
    input  wire logic       fail,
    input  wire logic [7:0] diag,
    output atf_cmd_t        got,
    output logic            eng_done,
    output logic            eng_drq,
    output logic            eng_abort,
    output logic            eng_gen_err,
    output logic            eng_wfault,
    output logic            eng_corrected_data_flag,
    output logic [7:0]      eng_diag
);
    // ****************************************
    // Completion delay
    // ****************************************
    logic [2:0] wait_cnt;   // Cycles left until the done pulse.
    // Latch the command and count down; done comes three cycles after the start.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wait_cnt <= 3'h0;
        end else if (cmd_start) begin
            wait_cnt <= 3'h3;
            got      <= cmd;
        end else if (wait_cnt != 3'h0) begin
            wait_cnt <= wait_cnt - 3'h1;
        end
    end
    // Flags are valid with done only, so a block that samples them late sees zeros and eng_diag inverted.
    assign eng_done    = (wait_cnt == 3'h1);
    assign eng_drq     = (wait_cnt != 3'h0);
    assign eng_abort   = eng_done & fail;
    assign eng_gen_err = eng_done & fail;
    assign eng_wfault  = eng_done & fail;
    assign eng_corrected_data_flag    = eng_done & fail;
    assign eng_diag    = eng_done ? diag : ~diag;
endmodule

// >>> atf_pkg.sv
// Constants, command carrier and state record of the task-file register block.
package atf_pkg;
    // Task-file offsets; 1, 7 and e carry different registers for read and write.
    localparam logic [3:0] ATF_OFS_ERRFEAT = 4'h1;
    localparam logic [3:0] ATF_OFS_COUNT   = 4'h2;
    localparam logic [3:0] ATF_OFS_SECTOR  = 4'h3;
    localparam logic [3:0] ATF_OFS_CYL_LO  = 4'h4;
    localparam logic [3:0] ATF_OFS_CYL_HI  = 4'h5;
    localparam logic [3:0] ATF_OFS_DRVHEAD = 4'h6;
    localparam logic [3:0] ATF_OFS_STATCMD = 4'h7;
    localparam logic [3:0] ATF_OFS_ALTCTL  = 4'he;
    localparam logic [3:0] ATF_OFS_DRVADDR = 4'hf;
    // Field positions.
    localparam int ATF_ERR_ABORTED_CMD_FLAG = 2;
    localparam int ATF_ERR_GEN  = 0;
    localparam int ATF_DH_LBA   = 6;
    localparam int ATF_DH_DRV   = 4;
    localparam int ATF_DC_SOFT_RESET_BIT  = 2;
    localparam int ATF_DC_INTERRUPT_DISABLE_BIT  = 1;
    localparam int ATF_ST_IDX   = 1;
    // Reset values and fixed codes.
    localparam logic [7:0]  ATF_DH_RESET   = 8'ha0;
    localparam logic [7:0]  ATF_ZERO8      = 8'h00;
    localparam logic [7:0]  ATF_DIAG_PASS  = 8'h01;
    localparam logic [8:0]  ATF_FULL_COUNT = 9'h100;
    localparam logic [8:0]  ATF_ONE_SECTOR = 9'h001;
    localparam logic [7:0]  ATF_CMD_DIAG   = 8'h90;
    localparam logic [7:0]  ATF_CMD_FORMAT = 8'h50;
    localparam logic [15:0] ATF_ID_WORD0   = 16'h848a;
    localparam logic [15:0] ATF_ID_WORD0_F = 16'h044a;
    localparam logic [7:0]  ATF_ID_MSW     = 8'h07;
    localparam logic [7:0]  ATF_ID_LSW     = 8'h08;

    // Controller sequencing states.
    typedef enum logic [1:0] {
        ATF_IDLE  = 2'b00,
        ATF_EXEC  = 2'b01,
        ATF_SOFT_RESET_BIT  = 2'b10
    } atf_state_e_t;

    // Command handed to the media engine.
    typedef struct packed {
        logic [7:0]  code;
        logic        lba_mode;
        logic [27:0] lba;
        logic [3:0]  head;
        logic [15:0] cyl;
        logic [7:0]  sector;
        logic [8:0]  count;
        logic        discard;
    } atf_cmd_t;

    // Whole register state of the block.
    typedef struct packed {
        atf_state_e_t fsm;
        logic [7:0]   error_flags;
        logic [7:0]   feature_select;
        logic [7:0]   transfer_sector_count;
        logic [7:0]   start_sector_number;
        logic [7:0]   cylinder_low_byte;
        logic [7:0]   cylinder_high_byte;
        logic [7:0]   drive_head_select;
        logic         busy_flag;
        logic         drive_ready_flag;
        logic         write_fault_flag;
        logic         corrected_data_flag;
        logic         error_bit;
        logic         irq_pending;
        logic         interrupt_disable_bit;
        logic         soft_reset_bit;
        logic         soft_reset_pulse;
        logic         cmd_start;
        atf_cmd_t     cmd;
        logic [7:0]   rdata;
        logic [15:0]  id_word;
    } atf_state_t;
endpackage

// >>> atf_task_file.sv
// Task-file registers, status and command dispatch of an ATA storage card.
//
// Behaviour
// - Rejected or failed command sets aborted flag.
// - General error sets error bit zero.
// - Diagnostic result code lands in error register.
// - Sector count zero means 256 sectors.
// - LBA built from sector, cylinders, head.
// - CHS uses head, cylinder and sector fields.
// - Drive/head bit six selects LBA addressing.
// - Answer only when drive bit matches card.
// - Busy set during operations; host ignores rest.
// - Primary status read drops interrupt request.
// - Alternate status read leaves interrupt alone.
// - Ready with seek complete; error waits read, except diagnostic (sets ready) and rejected opcode (keeps ready as it was).
// - Data request shows word may move.
// - Write fault bit five, corrected bit two.
// - Index status bit always reads zero.
// - Error status bit with details recorded.
// - Device control bit two forces soft reset.
// - Interrupt driven only when enabled and selected, or in memory mode.
// - Drive address shows inverted head, selects.
// - Diagnostic goes to drive zero, all run.
// - Decode power check, erase and identify.
// - Format track takes one sector, discards.
// - Identify word zero and sector count.
`timescale 1ns/10ps
module atf_task_file
    import atf_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [3:0]  host_addr,
    input  wire logic        host_rd,
    input  wire logic        host_wr,
    input  wire logic [7:0]  host_wdata,
    output logic      [7:0]  host_rdata,
    input  wire logic        memory_mode,
    input  wire logic        copy_number_field,
    input  wire logic        fixed_media,
    input  wire logic [31:0] total_sectors,
    input  wire logic [7:0]  id_index,
    output logic      [15:0] id_word,
    output logic             cmd_start,
    output atf_cmd_t         cmd,
    input  wire logic        eng_done,
    input  wire logic        eng_drq,
    input  wire logic        eng_abort,
    input  wire logic        eng_gen_err,
    input  wire logic        eng_wfault,
    input  wire logic        eng_corrected_data_flag,
    input  wire logic [7:0]  eng_diag,
    output logic             soft_reset_pulse,
    output logic             host_interrupt_request,
    output logic             host_interrupt_request_oe
);

    // ****************************************************************
    // State record and decode helpers
    // ****************************************************************
    atf_state_t s;           // Registered state.
    atf_state_t next_s;      // Next value of the state.
    logic       selected;    // Drive bit names this card.
    logic [7:0] status_byte; // Status as the host sees it.
    logic [7:0] drv_addr;    // Drive address read-back value.
    logic       done_now;    // Engine completion while executing.

    // Every listed opcode is accepted; anything else is aborted.
    function automatic logic atf_known(input logic [7:0] c);
        logic k;
        k = 1'b0;
        unique case (c[7:4])
            4'h1, 4'h7: begin
                k = 1'b1;
            end
            default: begin
                k = c inside {8'he5, 8'h98, 8'h90, 8'hc0, 8'h50, 8'hec,
                    8'he3, 8'h97, 8'he1, 8'h95, 8'h91, 8'h00, 8'he4,
                    8'hc8, 8'hc4, 8'h22, 8'h23, 8'h20, 8'h21, 8'h40,
                    8'h41, 8'h03, 8'hef, 8'hc6, 8'he6, 8'h99, 8'he2,
                    8'h96, 8'he0, 8'h94, 8'h87, 8'hf5, 8'he8, 8'hca,
                    8'h32, 8'h33, 8'hc5, 8'hcd, 8'h30, 8'h31, 8'h38,
                    8'h3c};
            end
        endcase
        return k;
    endfunction

    // Card answers only when the drive bit equals its copy number.
    assign selected = s.drive_head_select[ATF_DH_DRV] == copy_number_field;
    assign done_now = (s.fsm == ATF_EXEC) && eng_done;

    // Seek complete mirrors ready; index is tied low; data request
    // follows the engine only while a command runs.
    assign status_byte = {s.busy_flag,
                          s.drive_ready_flag,
                          s.write_fault_flag,
                          s.drive_ready_flag,
                          eng_drq && (s.fsm == ATF_EXEC),
                          s.corrected_data_flag,
                          1'b0,
                          s.error_bit};

    // Bit 7 reads low, bit 6 (write gate) unused and high.
    assign drv_addr = {1'b0, 1'b1,
                       ~s.drive_head_select[3:0],
                       ~(s.drive_head_select[ATF_DH_DRV]),
                       s.drive_head_select[ATF_DH_DRV]};

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // Order matters: the status-read clear is applied before the
    // completion set, so a finishing command is never lost.
    always_comb begin
        next_s = s;
        next_s.cmd_start = 1'b0;
        next_s.soft_reset_pulse = 1'b0;

        // Host reads: data is registered, so it appears one edge later.
        if (host_rd) begin
            next_s.rdata = ATF_ZERO8;
            if (selected) begin
                unique case (host_addr)
                    ATF_OFS_ERRFEAT: next_s.rdata = s.error_flags;
                    ATF_OFS_COUNT:   next_s.rdata = s.transfer_sector_count;
                    ATF_OFS_SECTOR:  next_s.rdata = s.start_sector_number;
                    ATF_OFS_CYL_LO:  next_s.rdata = s.cylinder_low_byte;
                    ATF_OFS_CYL_HI:  next_s.rdata = s.cylinder_high_byte;
                    ATF_OFS_DRVHEAD: next_s.rdata = s.drive_head_select;
                    ATF_OFS_STATCMD: begin
                        next_s.rdata = status_byte;
                        next_s.irq_pending = 1'b0;
                        if (!s.busy_flag) begin
                            next_s.drive_ready_flag = 1'b1;
                        end
                    end
                    ATF_OFS_ALTCTL:  next_s.rdata = status_byte;
                    ATF_OFS_DRVADDR: next_s.rdata = drv_addr;
                    default:         next_s.rdata = ATF_ZERO8;
                endcase
            end
        end

        // Host writes. Parameter writes while busy are dropped because the
        // host must only load them with the card ready.
        if (host_wr) begin
            unique case (host_addr)
                ATF_OFS_ALTCTL: begin
                    next_s.interrupt_disable_bit = host_wdata[ATF_DC_INTERRUPT_DISABLE_BIT];
                    next_s.soft_reset_bit = host_wdata[ATF_DC_SOFT_RESET_BIT];
                end
                ATF_OFS_DRVHEAD: begin
                    if (!s.busy_flag) begin
                        next_s.drive_head_select = host_wdata;
                    end
                end
                ATF_OFS_STATCMD: begin
                    // Diagnostic runs on both cards whatever the drive bit.
                    if (!s.busy_flag &&
                        (selected || host_wdata == ATF_CMD_DIAG)) begin
                        next_s.error_flags = ATF_ZERO8;
                        next_s.write_fault_flag = 1'b0;
                        next_s.corrected_data_flag = 1'b0;
                        if (atf_known(host_wdata)) begin
                            next_s.fsm = ATF_EXEC;
                            next_s.busy_flag = 1'b1;
                            next_s.drive_ready_flag = 1'b0;
                            next_s.error_bit = 1'b0;
                            next_s.cmd_start = 1'b1;
                            next_s.cmd.code = host_wdata;
                            next_s.cmd.lba_mode = s.drive_head_select[ATF_DH_LBA];
                            next_s.cmd.lba = {s.drive_head_select[3:0],
                                              s.cylinder_high_byte,
                                              s.cylinder_low_byte,
                                              s.start_sector_number};
                            next_s.cmd.head = s.drive_head_select[3:0];
                            next_s.cmd.cyl = {s.cylinder_high_byte,
                                              s.cylinder_low_byte};
                            next_s.cmd.sector = s.start_sector_number;
                            next_s.cmd.count = (s.transfer_sector_count == ATF_ZERO8)
                                ? ATF_FULL_COUNT
                                : {1'b0, s.transfer_sector_count};
                            next_s.cmd.discard = 1'b0;
                            if (host_wdata == ATF_CMD_FORMAT) begin
                                next_s.cmd.count = ATF_ONE_SECTOR;
                                next_s.cmd.discard = 1'b1;
                            end
                        end else begin
                            // Unknown opcode: finish at once with abort.
                            next_s.error_flags[ATF_ERR_ABORTED_CMD_FLAG] = 1'b1;
                            next_s.error_bit = 1'b1;
                            next_s.busy_flag = 1'b0;
                            next_s.irq_pending = 1'b1;
                        end
                    end
                end
                default: begin
                    if (!s.busy_flag && selected) begin
                        unique case (host_addr)
                            ATF_OFS_ERRFEAT: next_s.feature_select = host_wdata;
                            ATF_OFS_COUNT:   next_s.transfer_sector_count = host_wdata;
                            ATF_OFS_SECTOR:  next_s.start_sector_number = host_wdata;
                            ATF_OFS_CYL_LO:  next_s.cylinder_low_byte = host_wdata;
                            ATF_OFS_CYL_HI:  next_s.cylinder_high_byte = host_wdata;
                            default: begin
                            end
                        endcase
                    end
                end
            endcase
        end

        // Command completion from the media engine.
        if (done_now) begin
            next_s.fsm = ATF_IDLE;
            next_s.busy_flag = 1'b0;
            next_s.irq_pending = 1'b1;
            next_s.write_fault_flag = eng_wfault;
            next_s.corrected_data_flag = eng_corrected_data_flag;
            if (s.cmd.code == ATF_CMD_DIAG) begin
                next_s.error_flags = eng_diag;
                next_s.error_bit = eng_diag != ATF_DIAG_PASS;
                next_s.drive_ready_flag = 1'b1;
            end else begin
                next_s.error_flags[ATF_ERR_ABORTED_CMD_FLAG] = eng_abort;
                next_s.error_flags[ATF_ERR_GEN] = eng_gen_err;
                next_s.error_bit = eng_abort | eng_gen_err | eng_wfault;
                // After an error ready stays low until status is read.
                next_s.drive_ready_flag = !(eng_abort | eng_gen_err | eng_wfault);
            end
        end

        // Soft reset holds the task file in its reset values while the bit
        // stays set, and leaves a passing diagnostic code on release.
        if (next_s.soft_reset_bit) begin
            next_s.soft_reset_pulse = !s.soft_reset_bit;
            next_s.fsm = ATF_SOFT_RESET_BIT;
            next_s.busy_flag = 1'b1;
            next_s.drive_ready_flag = 1'b0;
            next_s.irq_pending = 1'b0;
            next_s.cmd_start = 1'b0;
            next_s.transfer_sector_count = ATF_DIAG_PASS;
            next_s.start_sector_number = ATF_DIAG_PASS;
            next_s.cylinder_low_byte = ATF_ZERO8;
            next_s.cylinder_high_byte = ATF_ZERO8;
            next_s.drive_head_select = ATF_DH_RESET;
        end else if (s.fsm == ATF_SOFT_RESET_BIT) begin
            next_s.fsm = ATF_IDLE;
            next_s.busy_flag = 1'b0;
            next_s.drive_ready_flag = 1'b1;
            next_s.error_bit = 1'b0;
            next_s.error_flags = ATF_DIAG_PASS;
        end

        // Identify block words are served from a register.
        unique case (id_index)
            ATF_ZERO8: next_s.id_word = fixed_media ? ATF_ID_WORD0_F
                                                    : ATF_ID_WORD0;
            ATF_ID_MSW: next_s.id_word = total_sectors[31:16];
            ATF_ID_LSW: next_s.id_word = total_sectors[15:0];
            default:    next_s.id_word = 16'h0000;
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Reset leaves the card ready, idle, drive 0 and interrupts enabled.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s <= '0;
            s.drive_head_select <= ATF_DH_RESET;
            s.drive_ready_flag <= 1'b1;
            s.error_flags <= ATF_DIAG_PASS;
            s.transfer_sector_count <= ATF_DIAG_PASS;
            s.start_sector_number <= ATF_DIAG_PASS;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign host_rdata       = s.rdata;
    assign id_word          = s.id_word;
    assign cmd_start        = s.cmd_start;
    assign cmd              = s.cmd;
    assign soft_reset_pulse = s.soft_reset_pulse;
    // The request pin is active low; memory mode ignores the disable bit.
    assign host_interrupt_request = !s.irq_pending;
    assign host_interrupt_request_oe = memory_mode ||
        (!s.interrupt_disable_bit && selected);

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence atf_status_rd;
        host_rd && host_addr == ATF_OFS_STATCMD && selected && !done_now;
    endsequence

    sequence atf_alt_rd;
        host_rd && host_addr == ATF_OFS_ALTCTL && !done_now && !host_wr
            && s.fsm == ATF_IDLE;
    endsequence

    // Host write that raises the soft reset bit from low; a repeat write of
    // the bit while it already stands high makes no second pulse.
    sequence atf_soft_reset_bit_rise;
        host_wr && host_addr == ATF_OFS_ALTCTL && host_wdata[ATF_DC_SOFT_RESET_BIT]
            && !s.soft_reset_bit;
    endsequence

    AST_STATUS_CLEARS_IRQ: assert property (atf_status_rd |=>
        host_interrupt_request) else $error("status read left irq");
    AST_ALT_KEEPS_IRQ: assert property (atf_alt_rd |=>
        $stable(host_interrupt_request)) else $error("alt read moved irq");
    AST_INDEX_ZERO: assert property (host_rd |=>
        !host_rdata[ATF_ST_IDX] || $past(host_addr) != ATF_OFS_STATCMD)
        else $error("index bit set");
    AST_ZERO_COUNT: assert property (cmd_start && cmd.discard == 1'b0 &&
        $past(s.transfer_sector_count) == ATF_ZERO8 |-> cmd.count == ATF_FULL_COUNT)
        else $error("zero count not 256");
    AST_UNKNOWN_ABORT: assert property (host_wr && host_addr == ATF_OFS_STATCMD
        && selected && !s.busy_flag && !atf_known(host_wdata) && !done_now
        && !s.soft_reset_bit |=> s.error_bit && s.error_flags[ATF_ERR_ABORTED_CMD_FLAG]
        && !s.busy_flag && !host_interrupt_request) else $error("no abort");
    AST_SOFT_RESET_BIT_BUSY: assert property (atf_soft_reset_bit_rise |=>
        s.busy_flag && soft_reset_pulse ##1 !soft_reset_pulse)
        else $error("soft reset not taken");
    AST_IRQ_HIZ: assert property (!memory_mode && s.interrupt_disable_bit
        |-> !host_interrupt_request_oe) else $error("irq driven while off");
    AST_FORMAT_ONE: assert property (cmd_start && cmd.code == ATF_CMD_FORMAT
        |-> cmd.count == ATF_ONE_SECTOR && cmd.discard) else $error("format count");
    // A soft reset written in the finishing cycle legally keeps the card busy.
    AST_DONE_BUSY: assert property (done_now && !s.soft_reset_bit
        |=> !s.busy_flag || s.soft_reset_bit) else $error("busy stuck");
endmodule

// >>> tb_atf_task_file.sv
// Self-checking testbench of the task-file register block.
`timescale 1ns/10ps
module tb_atf_task_file;
    import atf_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    localparam logic [31:0] CAP = 32'h0012_3456;  // Card capacity in sectors.
    logic        sys_clk = 1'b0, reset = 1'b1, host_rd = 1'b0, host_wr = 1'b0, fail = 1'b0;
    logic        mem_mode = 1'b0, copy_no = 1'b0, fixed = 1'b0;
    logic [3:0]  host_addr = 4'h0;
    logic [7:0]  host_wdata = 8'h00, id_index = 8'h00, diag = 8'h03, host_rdata, eng_diag, s;
    logic [15:0] id_word;
    logic        cmd_start, eng_done, eng_drq, eng_abort, eng_gen_err, eng_wfault, eng_corrected_data_flag;
    logic        soft_reset_pulse, irq_n, irq_oe;
    atf_cmd_t    cmd, got;
    int          n_mismatch = 0, n_checks = 0, n_pulse = 0;

    atf_task_file dut (.sys_clk, .reset, .host_addr, .host_rd, .host_wr, .host_wdata,
        .host_rdata, .memory_mode(mem_mode), .copy_number_field(copy_no), .fixed_media(fixed),
        .total_sectors(CAP), .id_index, .id_word, .cmd_start, .cmd, .eng_done, .eng_drq,
        .eng_abort, .eng_gen_err, .eng_wfault, .eng_corrected_data_flag, .eng_diag, .soft_reset_pulse,
        .host_interrupt_request(irq_n), .host_interrupt_request_oe(irq_oe));
    atf_engine_model eng (.sys_clk, .reset, .cmd_start, .cmd, .fail, .diag, .got, .eng_done,
        .eng_drq, .eng_abort, .eng_gen_err, .eng_wfault, .eng_corrected_data_flag, .eng_diag);

    always #12.5 sys_clk = ~sys_clk;
    // Count soft reset pulses so a stretched or missing pulse shows up.
    always @(posedge sys_clk) if (soft_reset_pulse === 1'b1) n_pulse++;

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        host_addr  = a;
        host_wdata = d;
        host_wr    = 1'b1;
        @(negedge sys_clk);
        host_wr = 1'b0;
    endtask
    // Read data is registered at the strobe edge and settled by the next falling edge.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        host_addr = a;
        host_rd   = 1'b1;
        @(negedge sys_clk);
        host_rd = 1'b0;
        d       = host_rdata;
    endtask
    task automatic load(input logic [7:0] v [5]);
        foreach (v[k]) wr(ATF_OFS_COUNT + 4'(k), v[k]);
    endtask
    // Poll the no-acknowledge status so the interrupt stays visible.
    task automatic wait_idle();
        int i;
        for (i = 0; i < 40; i++) begin
            rd(ATF_OFS_ALTCTL, s);
            if (s[7] === 1'b0) break;
        end
        if (i == 40) begin
            n_mismatch++;
            close_out();
        end
    endtask
    // An unselected card reads back zero, so wait for its request instead.
    task automatic wait_irq();
        int i;
        for (i = 0; i < 40; i++) begin
            @(negedge sys_clk);
            if (irq_n === 1'b0) break;
        end
        if (i == 40) begin
            n_mismatch++;
            close_out();
        end
    endtask
    task automatic run(input logic [7:0] code);
        wr(ATF_OFS_STATCMD, code);
        wait_idle();
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_lba();
        rd(ATF_OFS_STATCMD, s); chk({s, irq_n}, 9'h0a1);
        rd(ATF_OFS_ERRFEAT, s); chk(s, ATF_DIAG_PASS);
        wr(ATF_OFS_ALTCTL, 8'h08);
        load('{8'h00, 8'h11, 8'h22, 8'h33, 8'he5});
        wr(ATF_OFS_STATCMD, 8'h20);
        rd(ATF_OFS_ALTCTL, s); chk({s[7], s[3]}, 2'b11);
        wait_idle();
        chk({got.lba_mode, got.lba}, {1'b1, 28'h5332211});
        chk(got.count, ATF_FULL_COUNT);
        chk({irq_n, irq_oe}, 2'b01);
        rd(ATF_OFS_ALTCTL, s); chk({s, irq_n}, 9'h0a0);
        rd(ATF_OFS_STATCMD, s); chk({s, irq_n}, 9'h0a1);
        $display("lba test done");
    endtask
    task automatic t_fmt_err();
        load('{8'h07, 8'h11, 8'h22, 8'h33, 8'ha3});
        run(ATF_CMD_FORMAT);
        chk({got.lba_mode, got.head, got.cyl, got.sector}, {1'b0, 4'h3, 16'h3322, 8'h11});
        chk({got.count, got.discard}, {ATF_ONE_SECTOR, 1'b1});
        fail = 1'b1;
        run(8'h30);
        fail = 1'b0;
        rd(ATF_OFS_ERRFEAT, s); chk(s, 8'h05);
        rd(ATF_OFS_STATCMD, s); chk(s, 8'h25);
        rd(ATF_OFS_STATCMD, s); chk(s[6], 1'b1);
        run(8'h02);
        rd(ATF_OFS_ERRFEAT, s); chk({s[2], irq_n}, 2'b10);
        rd(ATF_OFS_STATCMD, s); chk({s[7], s[0], irq_n}, 3'b011);
        $display("format and error test done");
    endtask
    task automatic t_sel();
        logic [7:0] codes [4] = '{8'he5, 8'h98, 8'hc0, 8'hec};
        wr(ATF_OFS_DRVHEAD, 8'hb0);
        rd(ATF_OFS_COUNT, s); chk({s, irq_oe}, 9'h000);
        @(negedge sys_clk) copy_no = 1'b1;
        rd(ATF_OFS_COUNT, s); chk({s, irq_oe}, 9'h00f);
        copy_no = 1'b0;
        wr(ATF_OFS_STATCMD, ATF_CMD_DIAG);
        wait_irq();
        wr(ATF_OFS_DRVHEAD, 8'ha5);
        rd(ATF_OFS_ERRFEAT, s); chk(s, diag);
        rd(ATF_OFS_DRVADDR, s); chk(s, 8'h6a);
        foreach (codes[k]) begin
            run(codes[k]);
            rd(ATF_OFS_ERRFEAT, s); chk({got.code, s[2]}, {codes[k], 1'b0});
        end
        $display("select and code test done");
    endtask
    task automatic t_soft_reset_bit_id();
        wr(ATF_OFS_ALTCTL, 8'h0c);
        rd(ATF_OFS_ALTCTL, s); chk(s[7], 1'b1);
        wr(ATF_OFS_ALTCTL, 8'h08);
        rd(ATF_OFS_STATCMD, s); chk(s, 8'h50);
        rd(ATF_OFS_DRVHEAD, s); chk({s, n_pulse[0]}, {ATF_DH_RESET, 1'b1});
        wr(ATF_OFS_ALTCTL, 8'h0a);
        chk(irq_oe, 1'b0);
        mem_mode = 1'b1;
        @(negedge sys_clk) chk(irq_oe, 1'b1);
        mem_mode = 1'b0;
        wr(ATF_OFS_ALTCTL, 8'h08);
        @(negedge sys_clk) id_index = 8'h00;
        @(negedge sys_clk) chk(id_word, ATF_ID_WORD0);
        fixed = 1'b1;
        @(negedge sys_clk) chk(id_word, ATF_ID_WORD0_F);
        fixed = 1'b0;
        id_index = ATF_ID_MSW;
        @(negedge sys_clk) chk(id_word, CAP[31:16]);
        id_index = ATF_ID_LSW;
        @(negedge sys_clk) chk(id_word, CAP[15:0]);
        $display("soft reset and identify test done");
    endtask

    initial begin
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        t_lba();
        t_fmt_err();
        t_sel();
        t_soft_reset_bit_id();
        close_out();
    end
endmodule
